// file: pkg/hmtb_pkg.sv
package hmtb_pkg;

  // Register byte offsets on the processor bus
  localparam logic [7:0] HMTB_OFS_CFG = 8'h00;
  localparam logic [7:0] HMTB_OFS_SHIFT = 8'h04;
  localparam logic [7:0] HMTB_OFS_LSR = 8'h08;
  localparam logic [7:0] HMTB_OFS_LCR = 8'h0c;
  localparam logic [7:0] HMTB_OFS_MCR = 8'h10;
  localparam logic [7:0] HMTB_OFS_FCR = 8'h14;
  localparam logic [7:0] HMTB_OFS_PEND = 8'h18;
  localparam logic [7:0] HMTB_OFS_VEC = 8'h1c;
  localparam logic [7:0] HMTB_OFS_CTL = 8'h20;
  localparam logic [7:0] HMTB_OFS_RELOAD = 8'h24;

  // Host-side register addresses
  localparam logic [2:0] HMTB_HA_THR = 3'h0;
  localparam logic [2:0] HMTB_HA_FCR = 3'h2;
  localparam logic [2:0] HMTB_HA_LCR = 3'h3;
  localparam logic [2:0] HMTB_HA_MCR = 3'h4;
  localparam logic [2:0] HMTB_HA_LSR = 3'h5;

  // Field positions
  localparam int HMTB_CFG_DAISY = 0;
  localparam int HMTB_CFG_MODE = 1;
  localparam int HMTB_CFG_MUX = 2;
  localparam int HMTB_CTL_DLY = 0;
  localparam int HMTB_CTL_DBUF = 1;
  localparam int HMTB_CTL_VIS = 2;
  localparam int HMTB_CTL_FRST = 3;
  localparam int HMTB_PND_FCR = 1;
  localparam int HMTB_PND_LCR = 3;
  localparam int HMTB_PND_MCR = 4;
  localparam int HMTB_LSR_HOLDING_EMPTY_FLAG = 5;
  localparam int HMTB_LSR_TRANSMITTER_EMPTY_FLAG = 6;

  // Reset values
  localparam logic [7:0] HMTB_CFG_RST = 8'h00;
  localparam logic [3:0] HMTB_CTL_RST = 4'h0;
  localparam logic [7:0] HMTB_RELOAD_RST = 8'h0a;

  // Interrupt status codes for vector bits 3:1
  localparam logic [2:0] HMTB_IC_NONE = 3'h0;
  localparam logic [2:0] HMTB_IC_FCR = 3'h1;
  localparam logic [2:0] HMTB_IC_LCR = 3'h3;
  localparam logic [2:0] HMTB_IC_MCR = 3'h4;

  // Character timer tick: period in ns, count derived from 100 MHz clock
  localparam int HMTB_CLK_NS = 10;
  localparam int HMTB_TICK_NS = 1000;
  localparam int HMTB_TICK_CYC = HMTB_TICK_NS / HMTB_CLK_NS;

  typedef enum logic [1:0] {
    HMTB_PIN_DMA,
    HMTB_PIN_CHB,
    HMTB_PIN_HOST
  } hmtb_pin_e;

  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic [2:0] addr;
    logic [7:0] data;
  } hmtb_host_s;

endpackage

// file: core/hmtb_core.sv
`timescale 1ns/1ps
module hmtb_core import hmtb_pkg::*; #(
  parameter int TICK_CYC = HMTB_TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Host parallel port (asynchronous pins)
  input wire logic i_host_wr_n,
  input wire logic i_host_rd_n,
  input wire logic [2:0] i_host_addr,
  input wire logic [7:0] i_host_data,
  output logic [7:0] o_host_data,
  output logic o_host_data_oe,
  // Serial controller interrupt sharing the processor input
  input wire logic i_serial_irq,
  output logic o_shared_irq,
  output logic o_emul_first,
  output logic o_tx_irq,
  output logic o_tx_dma_req,
  output logic o_emul_en,
  output logic o_chb_out_en,
  output logic o_pio_en,
  output hmtb_pin_e o_pin_fn
);

  // Host pin synchroniser: three stages
  hmtb_host_s s1_r, s2_r, s3_r;
  hmtb_host_s s1_nxt, s2_nxt, s3_nxt;
  logic wr_st_r, wr_st_nxt, rd_st_r, rd_st_nxt;
  logic h_wr, h_rd_act;

  always_comb begin
    s1_nxt = hmtb_host_s'{i_host_wr_n, i_host_rd_n, i_host_addr, i_host_data};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    wr_st_nxt = wr_st_r;
    rd_st_nxt = rd_st_r;
    // A change counts only once the last two stages agree
    if (s2_r.wr_n == s3_r.wr_n) begin
      wr_st_nxt = s3_r.wr_n;
    end
    if (s2_r.rd_n == s3_r.rd_n) begin
      rd_st_nxt = s3_r.rd_n;
    end
    h_wr = wr_st_r & ~wr_st_nxt;
    h_rd_act = ~rd_st_r;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      wr_st_r <= 1'b1;
      rd_st_r <= 1'b1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      wr_st_r <= wr_st_nxt;
      rd_st_r <= rd_st_nxt;
    end
  end

  // Decoded host writes, all on the processor clock
  logic hw_thr, hw_fcr, hw_lcr, hw_mcr;
  assign hw_thr = h_wr && s3_r.addr == HMTB_HA_THR;
  assign hw_fcr = h_wr && s3_r.addr == HMTB_HA_FCR;
  assign hw_lcr = h_wr && s3_r.addr == HMTB_HA_LCR;
  assign hw_mcr = h_wr && s3_r.addr == HMTB_HA_MCR;

  // AHB access decode; zero wait state, answer always OKAY
  logic acc, acc_rd, acc_wr;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  assign acc = i_hsel && i_htrans[1] && i_hready;
  assign acc_rd = acc && !i_hwrite;
  assign acc_wr = wr_pend_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_r;

  // Register and datapath state
  logic [7:0] cfg_r, cfg_nxt;
  logic [3:0] ctl_r, ctl_nxt;
  logic [7:0] reload_r, reload_nxt;
  logic [7:0] lcr_m_r, lcr_m_nxt, lcr_s_r, lcr_s_nxt;
  logic [7:0] mcr_m_r, mcr_m_nxt, mcr_s_r, mcr_s_nxt;
  logic [7:0] fcr_m_r, fcr_m_nxt, fcr_s_r, fcr_s_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic [7:0] vec_r, vec_nxt;
  logic [7:0] thr_r, thr_nxt, tsr_r, tsr_nxt;
  logic thr_full_r, thr_full_nxt, tsr_full_r, tsr_full_nxt;
  logic ovrn_r, ovrn_nxt;
  logic [7:0] tmr_r, tmr_nxt;
  logic expired_r, expired_nxt;
  logic htemt_r, htemt_nxt;
  logic [$clog2(TICK_CYC+1)-1:0] div_r, div_nxt;
  logic [7:0] hdo_r, hdo_nxt;
  logic tick, move, frst, host_transmitter_empty_flag;
  logic rd_lcr, rd_mcr, rd_fcr, rd_tsr, rd_pend;
  logic [2:0] icode;
  logic [7:0] lsr_host;

  assign frst = acc_wr && wr_addr_r == HMTB_OFS_CTL && i_hwdata[HMTB_CTL_FRST];
  assign rd_lcr = acc_rd && i_haddr == HMTB_OFS_LCR;
  assign rd_mcr = acc_rd && i_haddr == HMTB_OFS_MCR;
  assign rd_fcr = acc_rd && i_haddr == HMTB_OFS_FCR;
  assign rd_tsr = acc_rd && i_haddr == HMTB_OFS_SHIFT;
  assign rd_pend = acc_rd && i_haddr == HMTB_OFS_PEND;

  // Flags are evaluated combinationally from registered state; the byte
  // moves only at the edge, so pointers are stable when data transfers.
  always_comb begin
    tick = div_r == '0;
    div_nxt = tick ? ($clog2(TICK_CYC+1))'(TICK_CYC - 1) : div_r - 1'b1;
    move = thr_full_r && !tsr_full_r
      && (!ctl_r[HMTB_CTL_DLY] || expired_r || tmr_r == '0);
    host_transmitter_empty_flag = ctl_r[HMTB_CTL_DLY] ? htemt_r : !thr_full_r && !tsr_full_r;
    lsr_host = '0;
    lsr_host[HMTB_LSR_HOLDING_EMPTY_FLAG] = !thr_full_r;
    lsr_host[HMTB_LSR_TRANSMITTER_EMPTY_FLAG] = host_transmitter_empty_flag;
    if (pend_r[HMTB_PND_FCR]) begin
      icode = HMTB_IC_FCR;
    end else if (pend_r[HMTB_PND_LCR]) begin
      icode = HMTB_IC_LCR;
    end else if (pend_r[HMTB_PND_MCR]) begin
      icode = HMTB_IC_MCR;
    end else begin
      icode = HMTB_IC_NONE;
    end
  end

  always_comb begin
    wr_pend_nxt = acc && i_hwrite;
    wr_addr_nxt = acc ? i_haddr : wr_addr_r;
    cfg_nxt = cfg_r;
    ctl_nxt = ctl_r;
    ctl_nxt[HMTB_CTL_FRST] = 1'b0;
    reload_nxt = reload_r;
    vec_nxt = vec_r;
    thr_nxt = thr_r;
    tsr_nxt = tsr_r;
    thr_full_nxt = thr_full_r;
    tsr_full_nxt = tsr_full_r;
    ovrn_nxt = ovrn_r;
    tmr_nxt = tmr_r;
    expired_nxt = expired_r;
    htemt_nxt = htemt_r;
    pend_nxt = pend_r;
    // Master stages always capture host writes
    lcr_m_nxt = hw_lcr ? s3_r.data : lcr_m_r;
    mcr_m_nxt = hw_mcr ? s3_r.data : mcr_m_r;
    fcr_m_nxt = hw_fcr ? s3_r.data : fcr_m_r;
    // Slave stages hold still while either side reads them
    lcr_s_nxt = lcr_s_r;
    mcr_s_nxt = mcr_s_r;
    fcr_s_nxt = fcr_s_r;
    if (!rd_lcr && !(h_rd_act && s3_r.addr == HMTB_HA_LCR)) begin
      lcr_s_nxt = lcr_m_r;
    end
    if (!rd_mcr && !(h_rd_act && s3_r.addr == HMTB_HA_MCR)) begin
      mcr_s_nxt = mcr_m_r;
    end
    if (!rd_fcr) begin
      fcr_s_nxt = fcr_m_r;
    end
    // Pending bits: a processor read clears, a coincident host write wins
    if (rd_lcr) begin
      pend_nxt[HMTB_PND_LCR] = 1'b0;
    end
    if (rd_mcr) begin
      pend_nxt[HMTB_PND_MCR] = 1'b0;
    end
    if (rd_pend || rd_fcr) begin
      pend_nxt[HMTB_PND_FCR] = 1'b0;
      ovrn_nxt = 1'b0;
    end
    if (hw_lcr) begin
      pend_nxt[HMTB_PND_LCR] = 1'b1;
    end
    if (hw_mcr) begin
      pend_nxt[HMTB_PND_MCR] = 1'b1;
    end
    if (hw_fcr) begin
      pend_nxt[HMTB_PND_FCR] = 1'b1;
    end
    // Character delay timer counts on the divided tick
    if (tick && tmr_r != '0) begin
      tmr_nxt = tmr_r - 1'b1;
    end
    // Transmit path
    if (rd_tsr) begin
      tsr_full_nxt = 1'b0;
    end
    if (move) begin
      tsr_nxt = thr_r;
      tsr_full_nxt = 1'b1;
      thr_full_nxt = 1'b0;
      tmr_nxt = reload_r;
      expired_nxt = 1'b0;
    end
    if (hw_thr) begin
      if (thr_full_r && !move) begin
        ovrn_nxt = 1'b1;
        pend_nxt[HMTB_PND_FCR] = 1'b1;
      end else begin
        thr_nxt = s3_r.data;
        thr_full_nxt = 1'b1;
      end
      htemt_nxt = 1'b0;
    end else if (!tsr_full_r && !thr_full_r && tmr_r == '0) begin
      htemt_nxt = 1'b1;
      expired_nxt = 1'b1;
    end
    // Processor register writes
    if (acc_wr) begin
      case (wr_addr_r)
        HMTB_OFS_CFG: cfg_nxt = i_hwdata[7:0];
        HMTB_OFS_VEC: vec_nxt = i_hwdata[7:0];
        HMTB_OFS_CTL: ctl_nxt = i_hwdata[3:0];
        HMTB_OFS_RELOAD: reload_nxt = i_hwdata[7:0];
        default: ;
      endcase
    end
    if (frst) begin
      thr_full_nxt = 1'b0;
      tsr_full_nxt = 1'b0;
      tmr_nxt = '0;
      expired_nxt = 1'b1;
      htemt_nxt = 1'b1;
      ctl_nxt[HMTB_CTL_FRST] = 1'b0;
    end
    // Read data is fetched in the address phase for a zero-wait answer
    hrdata_nxt = '0;
    if (acc_rd) begin
      case (i_haddr)
        HMTB_OFS_CFG: hrdata_nxt[7:0] = cfg_r;
        HMTB_OFS_SHIFT: hrdata_nxt[7:0] = tsr_r;
        HMTB_OFS_LSR: hrdata_nxt[HMTB_LSR_TRANSMITTER_EMPTY_FLAG] = !tsr_full_r;
        HMTB_OFS_LCR: hrdata_nxt[7:0] = lcr_s_r;
        HMTB_OFS_MCR: hrdata_nxt[7:0] = mcr_s_r;
        HMTB_OFS_FCR: hrdata_nxt[7:0] = fcr_s_r;
        HMTB_OFS_PEND: hrdata_nxt[7:0] = pend_r | {7'h00, ovrn_r};
        HMTB_OFS_VEC: begin
          if (ctl_r[HMTB_CTL_VIS] && icode != HMTB_IC_NONE) begin
            hrdata_nxt[7:0] = {vec_r[7:4], icode, 1'b0};
          end else begin
            hrdata_nxt[7:0] = vec_r;
          end
        end
        HMTB_OFS_CTL: hrdata_nxt[3:0] = ctl_r;
        HMTB_OFS_RELOAD: hrdata_nxt[7:0] = reload_r;
        default: hrdata_nxt = '0;
      endcase
    end
    // Host read data
    case (s3_r.addr)
      HMTB_HA_LCR: hdo_nxt = lcr_s_r;
      HMTB_HA_MCR: hdo_nxt = mcr_s_r;
      HMTB_HA_LSR: hdo_nxt = lsr_host;
      default: hdo_nxt = '0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata_r <= '0;
      cfg_r <= HMTB_CFG_RST;
      ctl_r <= HMTB_CTL_RST;
      reload_r <= HMTB_RELOAD_RST;
      lcr_m_r <= '0;
      lcr_s_r <= '0;
      mcr_m_r <= '0;
      mcr_s_r <= '0;
      fcr_m_r <= '0;
      fcr_s_r <= '0;
      pend_r <= '0;
      vec_r <= '0;
      thr_r <= '0;
      tsr_r <= '0;
      thr_full_r <= 1'b0;
      tsr_full_r <= 1'b0;
      ovrn_r <= 1'b0;
      tmr_r <= '0;
      expired_r <= 1'b1;
      htemt_r <= 1'b1;
      div_r <= '0;
      hdo_r <= '0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      cfg_r <= cfg_nxt;
      ctl_r <= ctl_nxt;
      reload_r <= reload_nxt;
      lcr_m_r <= lcr_m_nxt;
      lcr_s_r <= lcr_s_nxt;
      mcr_m_r <= mcr_m_nxt;
      mcr_s_r <= mcr_s_nxt;
      fcr_m_r <= fcr_m_nxt;
      fcr_s_r <= fcr_s_nxt;
      pend_r <= pend_nxt;
      vec_r <= vec_nxt;
      thr_r <= thr_nxt;
      tsr_r <= tsr_nxt;
      thr_full_r <= thr_full_nxt;
      tsr_full_r <= tsr_full_nxt;
      ovrn_r <= ovrn_nxt;
      tmr_r <= tmr_nxt;
      expired_r <= expired_nxt;
      htemt_r <= htemt_nxt;
      div_r <= div_nxt;
      hdo_r <= hdo_nxt;
    end
  end

  assign o_host_data = hdo_r;
  assign o_host_data_oe = h_rd_act;

  // Mode and pin routing
  logic emul_irq;
  assign o_emul_en = cfg_r[HMTB_CFG_MODE];
  assign o_chb_out_en = !cfg_r[HMTB_CFG_MODE];
  assign o_pio_en = !cfg_r[HMTB_CFG_MODE];
  always_comb begin
    case (cfg_r[HMTB_CFG_MUX -: 2])
      2'h2: o_pin_fn = HMTB_PIN_CHB;
      2'h3: o_pin_fn = HMTB_PIN_HOST;
      default: o_pin_fn = HMTB_PIN_DMA;
    endcase
  end

  // Transmit request follows the shift buffer level directly
  assign o_tx_irq = tsr_full_r && o_emul_en;
  assign o_tx_dma_req = tsr_full_r && o_emul_en;
  assign emul_irq = o_emul_en && (tsr_full_r || icode != HMTB_IC_NONE || ovrn_r);
  assign o_shared_irq = emul_irq || i_serial_irq;
  assign o_emul_first = cfg_r[HMTB_CFG_DAISY];

endmodule // hmtb_core

// file: testbench/hmtb_properties.sv
`timescale 1ns/1ps
module hmtb_properties import hmtb_pkg::*; #(
  parameter int TICK_CYC = HMTB_TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_host_rd_n,
  input wire logic o_host_data_oe,
  input wire logic i_serial_irq,
  input wire logic o_shared_irq,
  input wire logic o_emul_first,
  input wire logic o_tx_irq,
  input wire logic o_tx_dma_req,
  input wire logic o_emul_en,
  input wire logic o_chb_out_en,
  input wire logic o_pio_en,
  input hmtb_pin_e o_pin_fn
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic take;
  assign take = i_hsel && i_htrans[1] && i_hready;
  sequence cfg_wr;
    take && i_hwrite && i_haddr == HMTB_OFS_CFG;
  endsequence
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready or error response");
  idle_rdata_a: assert property (!(take && !i_hwrite) |=> o_hrdata == 32'h0)
    else $error("read data outside a read data phase");
  mode_split_a: assert property (o_chb_out_en != o_emul_en && o_pio_en != o_emul_en)
    else $error("channel and port enables disagree with mode");
  cfg_mode_a: assert property (cfg_wr |=> ##1 o_emul_en == $past(i_hwdata[1]))
    else $error("mode output not taken from config write");
  cfg_daisy_a: assert property (cfg_wr |=> ##1 o_emul_first == $past(i_hwdata[0]))
    else $error("daisy order not taken from config write");
  pin_host_a: assert property (cfg_wr |=> ##1 (o_pin_fn == HMTB_PIN_HOST) ==
    ($past(i_hwdata[2:1]) == 2'b11))
    else $error("host pin routing wrong after config write");
  pin_chb_a: assert property (o_pin_fn == HMTB_PIN_CHB |-> !o_emul_en)
    else $error("channel pins routed in emulation mode");
  irq_share_a: assert property (i_serial_irq |-> o_shared_irq)
    else $error("serial interrupt lost on shared line");
  tx_req_a: assert property (o_tx_dma_req == o_tx_irq && (!o_tx_irq || o_emul_en))
    else $error("transmit irq and dma request differ");
  host_oe_a: assert property (!i_host_rd_n [*6] |-> o_host_data_oe)
    else $error("host data not driven during read");
  host_off_a: assert property (i_host_rd_n [*6] |-> !o_host_data_oe)
    else $error("host data driven while idle");
  cover property (o_tx_irq);
  cover property (o_pin_fn == HMTB_PIN_HOST);
  cover property (o_host_data_oe);
endmodule // hmtb_properties
bind hmtb_core hmtb_properties #(.TICK_CYC(TICK_CYC)) u_hmtb_properties (.i_clk, .i_srst,
  .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .i_hwdata, .o_hrdata, .o_hreadyout,
  .o_hresp, .i_host_rd_n, .o_host_data_oe, .i_serial_irq, .o_shared_irq, .o_emul_first,
  .o_tx_irq, .o_tx_dma_req, .o_emul_en, .o_chb_out_en, .o_pio_en, .o_pin_fn);

// file: testbench/hmtb_host_model.sv
`timescale 1ns/1ps
module hmtb_host_model import hmtb_pkg::*; (
  input wire logic i_clk,
  input wire logic [7:0] i_data,
  output hmtb_host_s o_host
);
  initial o_host = '{wr_n: 1'b1, rd_n: 1'b1, addr: 3'h7, data: 8'h5a};
  // Strobes are held six cycles, three times the two-cycle minimum, so no edge is missed
  task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge i_clk);
    o_host.addr <= a;
    o_host.data <= d;
    @(posedge i_clk);
    if (w) o_host.wr_n <= 1'b0;
    else o_host.rd_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    q = i_data;
    o_host.wr_n <= 1'b1;
    o_host.rd_n <= 1'b1;
    @(posedge i_clk);
    // Released data bus must not keep showing the last byte
    o_host.data <= ~d;
    repeat (4) @(posedge i_clk);
  endtask
endmodule // hmtb_host_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top import hmtb_pkg::*; ;
  localparam int TICK = 2;
  logic i_clk = 0, i_srst = 1, hsel = 0, hwrite = 0, dph = 0, sirq = 0;
  logic [7:0] haddr = 8'h00, hdata, q, b, b2;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, seed = 32'h2c47;
  logic hready, hresp, hdoe, tx_irq, dma, emul, chb, pio, first, shirq;
  hmtb_pin_e pin;
  hmtb_host_s hb;
  logic [63:0] exp_q[$];
  int n_errors = 0, checks_done = 0, cyc = 0, k;
  hmtb_core #(.TICK_CYC(TICK)) u_hmtb_core (.i_clk(i_clk), .i_srst(i_srst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready),
    .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_host_wr_n(hb.wr_n), .i_host_rd_n(hb.rd_n), .i_host_addr(hb.addr),
    .i_host_data(hb.data), .o_host_data(hdata), .o_host_data_oe(hdoe), .i_serial_irq(sirq),
    .o_shared_irq(shirq), .o_emul_first(first), .o_tx_irq(tx_irq), .o_tx_dma_req(dma),
    .o_emul_en(emul), .o_chb_out_en(chb), .o_pio_en(pio), .o_pin_fn(pin));
  hmtb_host_model u_hmtb_host_model (.i_clk(i_clk), .i_data(hdata), .o_host(hb));
  initial forever #5 i_clk = ~i_clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge i_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    dph <= !w;
    do @(posedge i_clk); while (hready !== 1'b1);
    dph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    exp_q.push_back({m, e & m});
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic hx(input logic w, input logic [2:0] a, input logic [7:0] d);
    u_hmtb_host_model.xfer(w, a, d, q);
  endtask
  always @(posedge i_clk) begin
    if (dph && hready && exp_q.size() > 0) begin
      chk(hrdata & exp_q[0][63:32], exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(HMTB_OFS_CFG, {24'h0, HMTB_CFG_RST});
    rd(HMTB_OFS_RELOAD, {24'h0, HMTB_RELOAD_RST});
    rd(8'hfc, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(HMTB_OFS_CFG, 1'b1, i);
      rd(HMTB_OFS_CFG, i);
      chk({emul, chb, pio, first}, {i[1], !i[1], !i[1], i[0]});
      chk(pin, i[2:1] == 3 ? HMTB_PIN_HOST : i[2:1] == 2 ? HMTB_PIN_CHB : HMTB_PIN_DMA);
    end
    sirq <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(shirq, 1'b1);
    sirq <= 1'b0;
    $display("test config done");
    bus(HMTB_OFS_CFG, 1'b1, 32'h2);
    b = rnd();
    b2 = rnd();
    hx(1'b0, HMTB_HA_LSR, 8'h0);
    chk(q[6:5], 2'b11);
    hx(1'b1, HMTB_HA_THR, b);
    chk({tx_irq, dma}, 2'b11);
    rd(HMTB_OFS_LSR, 32'h0, 32'h40);
    hx(1'b1, HMTB_HA_THR, b2);
    hx(1'b0, HMTB_HA_LSR, 8'h0);
    chk(q[6:5], 2'b00);
    rd(HMTB_OFS_SHIFT, b);
    rd(HMTB_OFS_SHIFT, b2);
    repeat (2) @(posedge i_clk);
    chk(tx_irq, 1'b0);
    rd(HMTB_OFS_LSR, 32'h40, 32'h40);
    hx(1'b0, HMTB_HA_LSR, 8'h0);
    chk(q[6:5], 2'b11);
    $display("test transmit done");
    bus(HMTB_OFS_CTL, 1'b1, 32'h4);
    bus(HMTB_OFS_VEC, 1'b1, 32'h50);
    hx(1'b1, HMTB_HA_MCR, 8'h0b);
    rd(HMTB_OFS_VEC, 32'h58);
    hx(1'b1, HMTB_HA_LCR, 8'h3c);
    rd(HMTB_OFS_VEC, 32'h56);
    hx(1'b1, HMTB_HA_FCR, 8'h40);
    rd(HMTB_OFS_VEC, 32'h52);
    rd(HMTB_OFS_PEND, 32'h1a, 32'h1e);
    rd(HMTB_OFS_VEC, 32'h56);
    rd(HMTB_OFS_LCR, 32'h3c, 32'hff);
    rd(HMTB_OFS_VEC, 32'h58);
    rd(HMTB_OFS_MCR, 32'h0b, 32'hff);
    rd(HMTB_OFS_VEC, 32'h50);
    $display("test mailbox done");
    bus(HMTB_OFS_RELOAD, 1'b1, 32'h40);
    bus(HMTB_OFS_CTL, 1'b1, 32'h9);
    hx(1'b1, HMTB_HA_THR, b);
    chk(tx_irq, 1'b1);
    hx(1'b1, HMTB_HA_THR, b2);
    rd(HMTB_OFS_SHIFT, b);
    repeat (2) @(posedge i_clk);
    chk(tx_irq, 1'b0);
    k = 0;
    while (tx_irq !== 1'b1 && k < 1000) begin
      @(posedge i_clk);
      k++;
    end
    chk(k > 20 && k < 1000, 1'b1);
    rd(HMTB_OFS_SHIFT, b2);
    k = 0;
    do begin
      hx(1'b0, HMTB_HA_LSR, 8'h0);
      k++;
    end while (q[6] !== 1'b1 && k < 40);
    chk({k > 1, q[6:5]}, 3'b111);
    $display("test delay done");
    print_verdict();
  end
endmodule // tb_top
